// ===== common/bvsr_pkg.sv
// constants and types for the buck voltage and ramp register bank
package bvsr_pkg;

  localparam logic [7:0] BVSR_ADDR_B1_VA   = 8'h23;
  localparam logic [7:0] BVSR_ADDR_B1_VB   = 8'h24;
  localparam logic [7:0] BVSR_ADDR_B1_RAMP = 8'h25;
  localparam logic [7:0] BVSR_ADDR_B0_VA   = 8'h26;
  localparam logic [7:0] BVSR_ADDR_B0_VB   = 8'h27;
  localparam logic [7:0] BVSR_ADDR_B0_RAMP = 8'h28;
  localparam logic [7:0] BVSR_ADDR_B2_L8   = 8'h42;

  localparam int         BVSR_NREG         = 7;
  localparam logic [7:0] BVSR_VOLT_MASK    = 8'h1F;
  localparam logic [7:0] BVSR_RAMP_MASK    = 8'h07;
  localparam logic [7:0] BVSR_FULL_MASK    = 8'hFF;
  localparam logic [7:0] BVSR_RESET_VAL    = 8'h00;
  localparam logic [1:0] BVSR_SEL_A        = 2'h0;

  // slot of each register in the bank, same order as the address map
  localparam int         BVSR_IDX_B1_VA    = 0;
  localparam int         BVSR_IDX_B1_VB    = 1;
  localparam int         BVSR_IDX_B1_RAMP  = 2;
  localparam int         BVSR_IDX_B0_VA    = 3;
  localparam int         BVSR_IDX_B0_VB    = 4;
  localparam int         BVSR_IDX_B0_RAMP  = 5;
  localparam int         BVSR_IDX_B2_L8    = 6;

  // field positions inside a register
  localparam int         BVSR_LSB          = 0;
  localparam int         BVSR_CODE_MSB     = 4;
  localparam int         BVSR_RAMP_MSB     = 2;
  localparam int         BVSR_L8_LSB       = 5;
  localparam int         BVSR_L8_MSB       = 7;

  // voltages in millivolts, ramp in uV/us, pwm in kHz
  localparam int         BVSR_B01_BASE_MV  = 725;
  localparam int         BVSR_B01_STEP_MV  = 25;
  localparam int         BVSR_B2_BASE_MV   = 3000;
  localparam int         BVSR_B2_STEP_MV   = 50;
  localparam int         BVSR_RAMP_BASE_UV = 110;
  localparam int         BVSR_PWM_KHZ      = 2250;

  typedef enum logic [1:0] {
    BVSR_ST_HOLD  = 2'b00,
    BVSR_ST_START = 2'b01
  } bvsr_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bvsr_req_t;

  typedef struct packed {
    logic [4:0] code;
    logic [2:0] ramp;
    logic       start;
  } bvsr_target_t;

endpackage : bvsr_pkg

// ===== rtl/bvsr_regs.sv
// buck voltage and ramp register bank behind the serial-bus register port
`timescale 1ns/1ns
module bvsr_regs
  import bvsr_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire bvsr_req_t    req,
  input  wire logic [1:0]   b0_sel,
  input  wire logic [1:0]   b0_go,
  input  wire logic [1:0]   b1_sel,
  input  wire logic [1:0]   b1_go,
  output logic [7:0]        rdata,
  output logic              rvalid,
  output bvsr_target_t      buck0_tgt,
  output bvsr_target_t      buck1_tgt,
  output logic [4:0]        buck2_voltage_code,
  output logic [2:0]        linear8_voltage_code
);

  // ----------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDRS [BVSR_NREG] = '{BVSR_ADDR_B1_VA, BVSR_ADDR_B1_VB,
      BVSR_ADDR_B1_RAMP, BVSR_ADDR_B0_VA, BVSR_ADDR_B0_VB, BVSR_ADDR_B0_RAMP,
      BVSR_ADDR_B2_L8};
  localparam logic [7:0] MASKS [BVSR_NREG] = '{BVSR_VOLT_MASK, BVSR_VOLT_MASK,
      BVSR_RAMP_MASK, BVSR_VOLT_MASK, BVSR_VOLT_MASK, BVSR_RAMP_MASK,
      BVSR_FULL_MASK};

  typedef struct packed {
    logic [BVSR_NREG-1:0][7:0] regs;
    logic [7:0]                rdata;
    logic                      rvalid;
    bvsr_target_t              t0;
    bvsr_target_t              t1;
    logic [1:0]                go0;
    logic [1:0]                go1;
  } bvsr_st_t;

  bvsr_st_t             st_reg;
  bvsr_st_t             st_next;
  logic [BVSR_NREG-1:0] hit;

  genvar g;
  generate
    for (g = 0; g < BVSR_NREG; g++) begin : g_dec
      assign hit[g] = (req.addr == ADDRS[g]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next        = st_reg;
    st_next.rvalid = req.rd;
    st_next.rdata  = BVSR_RESET_VAL;
    for (int i = 0; i < BVSR_NREG; i++) begin
      if (req.wr && hit[i]) begin
        st_next.regs[i] = req.wdata & MASKS[i];
      end
      if (req.rd && hit[i]) begin
        st_next.rdata = st_reg.regs[i];
      end
    end
    st_next.go0      = b0_go;
    st_next.go1      = b1_go;
    st_next.t0.start = 1'h0;
    st_next.t1.start = 1'h0;
    // newly raised go bit latches the target; a go level held high never retriggers
    if (|(b0_go & ~st_reg.go0)) begin
      if (b0_sel == BVSR_SEL_A) begin
        st_next.t0.code = st_reg.regs[BVSR_IDX_B0_VA][BVSR_CODE_MSB:BVSR_LSB];
      end else begin
        st_next.t0.code = st_reg.regs[BVSR_IDX_B0_VB][BVSR_CODE_MSB:BVSR_LSB];
      end
      st_next.t0.ramp  = st_reg.regs[BVSR_IDX_B0_RAMP][BVSR_RAMP_MSB:BVSR_LSB];
      st_next.t0.start = 1'h1;
    end
    if (|(b1_go & ~st_reg.go1)) begin
      if (b1_sel == BVSR_SEL_A) begin
        st_next.t1.code = st_reg.regs[BVSR_IDX_B1_VA][BVSR_CODE_MSB:BVSR_LSB];
      end else begin
        st_next.t1.code = st_reg.regs[BVSR_IDX_B1_VB][BVSR_CODE_MSB:BVSR_LSB];
      end
      st_next.t1.ramp  = st_reg.regs[BVSR_IDX_B1_RAMP][BVSR_RAMP_MSB:BVSR_LSB];
      st_next.t1.start = 1'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata                = st_reg.rdata;
  assign rvalid               = st_reg.rvalid;
  assign buck0_tgt            = st_reg.t0;
  assign buck1_tgt            = st_reg.t1;
  assign buck2_voltage_code   = st_reg.regs[BVSR_IDX_B2_L8][BVSR_CODE_MSB:BVSR_LSB];
  assign linear8_voltage_code = st_reg.regs[BVSR_IDX_B2_L8][BVSR_L8_MSB:BVSR_L8_LSB];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_mask_v;
    @(posedge clk) disable iff (!rst_n)
      (req.wr && req.addr == BVSR_ADDR_B0_VA)
        |=> ((st_reg.regs[BVSR_IDX_B0_VA] & ~BVSR_VOLT_MASK) == BVSR_RESET_VAL);
  endproperty
  a_mask_v: assert property (p_mask_v) else $error("voltage upper bits set");

  property p_mask_r;
    @(posedge clk) disable iff (!rst_n)
      (req.wr && req.addr == BVSR_ADDR_B1_RAMP)
        |=> (st_reg.regs[BVSR_IDX_B1_RAMP] == ($past(req.wdata) & BVSR_RAMP_MASK));
  endproperty
  a_mask_r: assert property (p_mask_r) else $error("ramp write wrong");

  property p_rd;
    @(posedge clk) disable iff (!rst_n)
      (req.rd && req.addr == BVSR_ADDR_B2_L8)
        |=> (rvalid && rdata == $past(st_reg.regs[BVSR_IDX_B2_L8]));
  endproperty
  a_rd: assert property (p_rd) else $error("read data wrong");

  property p_unmapped;
    @(posedge clk) disable iff (!rst_n)
      (req.rd && hit == '0) |=> (rdata == 8'h00);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");

  property p_sel_a;
    @(posedge clk) disable iff (!rst_n)
      ($rose(|b0_go) && b0_sel == BVSR_SEL_A) |=> (buck0_tgt.start
        && buck0_tgt.code == $past(st_reg.regs[BVSR_IDX_B0_VA][BVSR_CODE_MSB:BVSR_LSB]));
  endproperty
  a_sel_a: assert property (p_sel_a) else $error("buck0 select a wrong");

  property p_sel_b;
    @(posedge clk) disable iff (!rst_n)
      ($rose(|b1_go) && b1_sel != BVSR_SEL_A) |=> (buck1_tgt.start
        && buck1_tgt.code == $past(st_reg.regs[BVSR_IDX_B1_VB][BVSR_CODE_MSB:BVSR_LSB]));
  endproperty
  a_sel_b: assert property (p_sel_b) else $error("buck1 select b wrong");

  property p_start_pulse;
    @(posedge clk) disable iff (!rst_n)
      buck0_tgt.start |=> !buck0_tgt.start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start not a pulse");

  property p_b2;
    @(posedge clk) disable iff (!rst_n)
      (req.wr && req.addr == BVSR_ADDR_B2_L8)
        |=> (buck2_voltage_code == $past(req.wdata[BVSR_CODE_MSB:BVSR_LSB])
        && linear8_voltage_code == $past(req.wdata[BVSR_L8_MSB:BVSR_L8_LSB]));
  endproperty
  a_b2: assert property (p_b2) else $error("shared register split wrong");

  property p_sel_b0b;
    @(posedge clk) disable iff (!rst_n)
      ($rose(|b0_go) && b0_sel != BVSR_SEL_A) |=> (buck0_tgt.start
        && buck0_tgt.code == $past(st_reg.regs[BVSR_IDX_B0_VB][BVSR_CODE_MSB:BVSR_LSB]));
  endproperty
  a_sel_b0b: assert property (p_sel_b0b) else $error("buck0 select b wrong");

  property p_sel_b1a;
    @(posedge clk) disable iff (!rst_n)
      ($rose(|b1_go) && b1_sel == BVSR_SEL_A) |=> (buck1_tgt.start
        && buck1_tgt.code == $past(st_reg.regs[BVSR_IDX_B1_VA][BVSR_CODE_MSB:BVSR_LSB]));
  endproperty
  a_sel_b1a: assert property (p_sel_b1a) else $error("buck1 select a wrong");

  property p_ramp0;
    @(posedge clk) disable iff (!rst_n)
      $rose(|b0_go)
        |=> (buck0_tgt.ramp == $past(st_reg.regs[BVSR_IDX_B0_RAMP][BVSR_RAMP_MSB:BVSR_LSB]));
  endproperty
  a_ramp0: assert property (p_ramp0) else $error("buck0 ramp rate not latched");

  property p_ramp1;
    @(posedge clk) disable iff (!rst_n)
      $rose(|b1_go)
        |=> (buck1_tgt.ramp == $past(st_reg.regs[BVSR_IDX_B1_RAMP][BVSR_RAMP_MSB:BVSR_LSB]));
  endproperty
  a_ramp1: assert property (p_ramp1) else $error("buck1 ramp rate not latched");

  property p_start_pulse1;
    @(posedge clk) disable iff (!rst_n)
      buck1_tgt.start |=> !buck1_tgt.start;
  endproperty
  a_start_pulse1: assert property (p_start_pulse1) else $error("buck1 start not a pulse");

  property p_go_hold;
    @(posedge clk) disable iff (!rst_n)
      ($past(rst_n) && b0_go == $past(b0_go) && b1_go == $past(b1_go))
        |=> (!buck0_tgt.start && !buck1_tgt.start);
  endproperty
  a_go_hold: assert property (p_go_hold) else $error("start without a new go bit");

  property p_rd_valid;
    @(posedge clk) disable iff (!rst_n)
      req.rd |=> rvalid;
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read not answered");

  property p_rd_idle;
    @(posedge clk) disable iff (!rst_n)
      !req.rd |=> (!rvalid && rdata == BVSR_RESET_VAL);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read answer without a read");

  property p_unmapped_wr;
    @(posedge clk) disable iff (!rst_n)
      (req.wr && hit == '0) |=> (st_reg.regs == $past(st_reg.regs));
  endproperty
  a_unmapped_wr: assert property (p_unmapped_wr) else $error("unmapped write landed");

endmodule : bvsr_regs

// ===== sim/bvsr_host.sv
// host model driving the register port of the bank
`timescale 1ns/1ns
module bvsr_host
  import bvsr_pkg::*;
(
  input  wire logic       clk,
  output bvsr_req_t       req,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid
);
  initial req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(posedge clk);
    req <= '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    req <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req <= '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: 8'hA5};
    #1;
    d = rdata;
    v = rvalid;
  endtask : rd
endmodule : bvsr_host

// ===== sim/testbench.sv
// self-checking bench for the buck voltage and ramp register bank
`timescale 1ns/1ns
module testbench
  import bvsr_pkg::*;
;
  logic clk, rst_n, v;
  bvsr_req_t req;
  logic [1:0] b0_sel, b0_go, b1_sel, b1_go;
  logic [7:0] rdata, d;
  logic rvalid;
  bvsr_target_t buck0_tgt, buck1_tgt, t;
  logic [4:0] buck2_voltage_code;
  logic [2:0] linear8_voltage_code;
  logic [7:0] adr [7] = '{8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h42};
  logic [7:0] ex [7];
  logic [31:0] s;
  int error_cnt, num_checks, base;
  always #25 clk = ~clk;
  bvsr_host host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
  bvsr_regs dut (.clk(clk), .rst_n(rst_n), .req(req), .b0_sel(b0_sel), .b0_go(b0_go),
    .b1_sel(b1_sel), .b1_go(b1_go), .rdata(rdata), .rvalid(rvalid), .buck0_tgt(buck0_tgt),
    .buck1_tgt(buck1_tgt), .buck2_voltage_code(buck2_voltage_code),
    .linear8_voltage_code(linear8_voltage_code));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [7:0] msk(input int i);
    return (i == 6) ? 8'hFF : (i == 2 || i == 5) ? 8'h07 : 8'h1F;
  endfunction : msk
  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
    num_checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  initial begin
    {clk, rst_n, b0_sel, b0_go, b1_sel, b1_go} = '0;
    s = 32'h000109C3;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    foreach (adr[i]) begin
      host.rd(adr[i], d, v);
      chk("reset", 9'h000, {v ^ 1'h1, d});
    end
    host.wr(8'h29, 8'hFF);
    host.rd(8'h29, d, v);
    chk("unmapped", 9'h100, {v, d});
    for (int r = 0; r < 3; r++) begin
      foreach (adr[i]) begin
        s = lfsr(s);
        d = (r == 0) ? 8'hFF : s[7:0];
        host.wr(adr[i], d);
        ex[i] = d & msk(i);
      end
      foreach (adr[i]) begin
        host.rd(adr[i], d, v);
        chk("readback", {1'h1, ex[i]}, {v, d});
      end
    end
    chk("buck2", {4'h0, ex[6][4:0]}, {4'h0, buck2_voltage_code});
    chk("linear8", {6'h00, ex[6][7:5]}, {6'h00, linear8_voltage_code});
    for (int b = 0; b < 2; b++) for (int k = 0; k < 4; k++) begin
      base = b ? 0 : 3;
      @(posedge clk);
      if (b) {b1_sel, b1_go} <= {k[1:0], k[0] ? 2'h1 : 2'h2};
      else {b0_sel, b0_go} <= {k[1:0], k[0] ? 2'h1 : 2'h2};
      @(posedge clk);
      #1 t = b ? buck1_tgt : buck0_tgt;
      chk("target", {ex[base + (k != 0)][4:0], ex[base + 2][2:0], 1'h1}, t);
      @(posedge clk);
      {b0_go, b1_go} <= 4'h0;
      #1 t = b ? buck1_tgt : buck0_tgt;
      chk("start", 9'h000, {8'h00, t.start});
    end
    @(posedge clk);
    rst_n <= 1'h0;
    @(posedge clk);
    #1 chk("rst_rdata", 9'h000, {rvalid, rdata});
    chk("rst_codes", 9'h000, {1'h0, buck2_voltage_code, linear8_voltage_code});
    chk("rst_tgt", 9'h000, buck0_tgt | buck1_tgt);
    @(posedge clk);
    rst_n <= 1'h1;
    foreach (adr[i]) begin
      host.rd(adr[i], d, v);
      chk("rst_read", 9'h100, {v, d});
    end
    finish_test();
  end
endmodule : testbench
